// File: dpsc_host.sv
// host side controller for one port of an asynchronous dual-port sram
// assumes the memory pins are wired directly; data pins split in/out/oe
// Operation
// - address changes only with strobe high
// - strobe width covers output-off plus setup
// - in pair mode strobe waits busy access
// - no data drive while memory drives
// - recovery counted from first rising control
// - select low long enough before write end
// - address valid long enough before write end
// - data valid long enough before write end
// - select read keeps strobe high, gate low
module dpsc_host
	import dpsc_pkg::*;
#(
	parameter int ADDR_W = 11,
	parameter int DATA_W = 8
)(
	input  wire logic              clk_in,
	input  wire logic              reset_in,
	input  wire logic              req_in,
	input  wire logic              req_write_in,
	input  wire logic [ADDR_W-1:0] req_addr_in,
	input  wire logic [DATA_W-1:0] req_wdata_in,
	input  wire logic              pair_mode_in,
	output logic                   req_ready_out,
	output logic                   rdata_valid_out,
	output logic [DATA_W-1:0]      rdata_out,
	output logic [ADDR_W-1:0]      mem_addr_out,
	output logic                   mem_sel_n_out,
	output logic                   mem_we_n_out,
	output logic                   mem_oe_n_out,
	input  wire logic [DATA_W-1:0] mem_data_in,
	output logic [DATA_W-1:0]      mem_data_out,
	output logic                   mem_data_oe_out
);
	typedef struct packed {
		dpsc_state_t         st;
		logic [CNT_W-1:0]    cnt;
		logic                wr;
		logic                ready;
		logic                rvalid;
		logic [DATA_W-1:0]   rdata;
		logic [ADDR_W-1:0]   addr;
		logic                sel_n;
		logic                we_n;
		logic                oe_n;
		logic [DATA_W-1:0]   dout;
		logic                doe;
	} dpsc_regs_t;

	dpsc_regs_t s_q;
	dpsc_regs_t s_d;

	function automatic logic [CNT_W-1:0] dpsc_c(input int n);
		return CNT_W'(n - 1);
	endfunction : dpsc_c

	function automatic logic dpsc_done(input logic [CNT_W-1:0] c);
		return c == '0;
	endfunction : dpsc_done

	function automatic logic [CNT_W-1:0] dpsc_dec(input logic [CNT_W-1:0] c);
		return c - 1'b1;
	endfunction : dpsc_dec

	// output-off plus setup, width, select, address time
	// one count meets every write minimum; a faster grade only wastes cycles
	function automatic logic [CNT_W-1:0] dpsc_wr_len();
		int n;
		n = (WZ_DW_CYC > EW_CYC) ? WZ_DW_CYC : EW_CYC;
		n = (n > WP_CYC) ? n : WP_CYC;
		n = (n > AW_CYC) ? n : AW_CYC;
		return dpsc_c(n);
	endfunction : dpsc_wr_len

	always_comb
	begin
		s_d        = s_q;
		s_d.rvalid = 1'b0;
		case (s_q.st)
			DPSC_IDLE:
			begin
				s_d.ready = 1'b1;
				// a request while busy is dropped; the host must retry
				if (req_in && s_q.ready)
				begin
					s_d.ready = 1'b0;
					s_d.wr    = req_write_in;
					// address moves only with controls high
					s_d.addr  = req_addr_in;
					s_d.dout  = req_wdata_in;
					s_d.st    = DPSC_SETUP;
				end
			end
			DPSC_SETUP:
			begin
				// select falls; strobe falls with it only for a write outside pair mode, gate falls with it for a read
				s_d.sel_n = 1'b0;
				if (s_q.wr)
				begin
					// wait out busy access before strobe
					if (pair_mode_in)
					begin
						s_d.cnt = dpsc_c(BAA_CYC);
						s_d.st  = DPSC_WBUSY;
					end
					else
					begin
						s_d.we_n = 1'b0;
						// keep bus off while memory may drive
						s_d.cnt  = dpsc_wr_len();
						s_d.st   = DPSC_WRITE;
					end
				end
				else
				begin
					// strobe high, gate low, address already set
					s_d.oe_n = 1'b0;
					s_d.cnt  = dpsc_c(RC_CYC);
					s_d.st   = DPSC_READ;
				end
			end
			DPSC_WBUSY:
			begin
				if (dpsc_done(s_q.cnt))
				begin
					s_d.we_n = 1'b0;
					s_d.cnt  = dpsc_wr_len();
					s_d.st   = DPSC_WRITE;
				end
				else
					s_d.cnt = dpsc_dec(s_q.cnt);
			end
			DPSC_WRITE:
			begin
				// drive data only once outputs released
				s_d.doe = 1'b1;
				if (dpsc_done(s_q.cnt))
				begin
					// first rising control ends the write
					s_d.we_n  = 1'b1;
					s_d.sel_n = 1'b1;
					s_d.cnt   = dpsc_c(WR_CYC);
					s_d.st    = DPSC_RECOV;
				end
				else
					s_d.cnt = dpsc_dec(s_q.cnt);
			end
			DPSC_READ:
			begin
				if (dpsc_done(s_q.cnt))
				begin
					// sample once the later enable has settled
					s_d.rdata  = mem_data_in;
					s_d.rvalid = 1'b1;
					s_d.oe_n   = 1'b1;
					s_d.sel_n  = 1'b1;
					s_d.cnt    = dpsc_c(HZ_CYC);
					s_d.st     = DPSC_RECOV;
				end
				else
					s_d.cnt = dpsc_dec(s_q.cnt);
			end
			DPSC_RECOV:
			begin
				// data hold of zero; drop drive after controls rise
				s_d.doe = 1'b0;
				if (dpsc_done(s_q.cnt))
				begin
					s_d.ready = 1'b1;
					s_d.st    = DPSC_IDLE;
				end
				else
					s_d.cnt = dpsc_dec(s_q.cnt);
			end
			default:
			begin
				// an illegal code drops back to idle with every control released
				s_d = '0;
				s_d.st = DPSC_IDLE;
				s_d.sel_n = 1'b1;
				s_d.we_n = 1'b1;
				s_d.oe_n = 1'b1;
			end
		endcase
	end

	always_ff @(posedge clk_in or posedge reset_in)
	begin
		if (reset_in)
		begin
			s_q       <= '0;
			s_q.st    <= DPSC_IDLE;
			s_q.sel_n <= 1'b1;
			s_q.we_n  <= 1'b1;
			s_q.oe_n  <= 1'b1;
		end
		else
			s_q <= s_d;
	end

	assign req_ready_out   = s_q.ready;
	assign rdata_valid_out = s_q.rvalid;
	assign rdata_out       = s_q.rdata;
	assign mem_addr_out    = s_q.addr;
	assign mem_sel_n_out   = s_q.sel_n;
	assign mem_we_n_out    = s_q.we_n;
	assign mem_oe_n_out    = s_q.oe_n;
	assign mem_data_out    = s_q.dout;
	assign mem_data_oe_out = s_q.doe;
endmodule : dpsc_host

// File: dpsc_pkg.sv
// constants for the dual-port sram port host controller
// assumes a 100 mhz clock; times are in ns, counts in cycles
package dpsc_pkg;
	localparam int CLK_PERIOD_NS = 10;
	function automatic int dpsc_cyc_up(input int ns);
		int c;
		c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
		return (c < 1) ? 1 : c;
	endfunction : dpsc_cyc_up
	// slowest grade figures so every grade is served
	localparam int T_WP_NS     = 30;
	localparam int T_WZ_NS     = 25;
	localparam int T_DW_NS     = 20;
	localparam int T_EW_NS     = 40;
	localparam int T_AW_NS     = 40;
	localparam int T_WR_NS     = 0;
	localparam int T_BAA_NS    = 30;
	localparam int T_RC_NS     = 55;
	localparam int T_HZ_NS     = 25;
	localparam int WZ_DW_CYC   = dpsc_cyc_up(T_WZ_NS + T_DW_NS);
	localparam int WP_CYC      = dpsc_cyc_up(T_WP_NS);
	localparam int EW_CYC      = dpsc_cyc_up(T_EW_NS);
	localparam int AW_CYC      = dpsc_cyc_up(T_AW_NS);
	localparam int WR_CYC      = dpsc_cyc_up(T_WR_NS);
	localparam int BAA_CYC     = dpsc_cyc_up(T_BAA_NS);
	localparam int RC_CYC      = dpsc_cyc_up(T_RC_NS);
	localparam int HZ_CYC      = dpsc_cyc_up(T_HZ_NS);
	localparam int CNT_W       = 4;
	typedef enum logic [5:0] {
		DPSC_IDLE  = 6'h01,
		DPSC_SETUP = 6'h02,
		DPSC_WBUSY = 6'h04,
		DPSC_WRITE = 6'h08,
		DPSC_READ  = 6'h10,
		DPSC_RECOV = 6'h20
	} dpsc_state_t;
endpackage : dpsc_pkg

// File: dpsc_host_monitor.sv
// pin order checker for dpsc_host
// bound to every dpsc_host; sees its ports only
module dpsc_host_monitor
	import dpsc_pkg::*;
#(
	parameter int ADDR_W = 11,
	parameter int DATA_W = 8
)(
	input wire logic              clk_in,
	input wire logic              reset_in,
	input wire logic              pair_mode_in,
	input wire logic [ADDR_W-1:0] mem_addr_out,
	input wire logic              mem_sel_n_out,
	input wire logic              mem_we_n_out,
	input wire logic              mem_oe_n_out,
	input wire logic [DATA_W-1:0] mem_data_out,
	input wire logic              mem_data_oe_out
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk_in); endclocking
	default disable iff (reset_in);
	property p_adr; !$stable(mem_addr_out) |-> mem_we_n_out && $past(mem_we_n_out); endproperty
	a_adr: assert property (p_adr) else $error("addr moved");
	property p_wp; $fell(mem_we_n_out) |-> !mem_we_n_out [*5]; endproperty
	a_wp: assert property (p_wp) else $error("strobe short");
	property p_baa; $fell(mem_we_n_out) && pair_mode_in
		|-> $past(mem_addr_out, 3) == mem_addr_out && !$past(mem_sel_n_out, 3); endproperty
	a_baa: assert property (p_baa) else $error("busy wait short");
	property p_off; $rose(mem_data_oe_out) |-> !$past(mem_we_n_out) && mem_oe_n_out; endproperty
	a_off: assert property (p_off) else $error("data drive early");
	property p_ew; $rose(mem_we_n_out)
		|-> !$past(mem_sel_n_out, 4) && !$past(mem_sel_n_out); endproperty
	a_ew: assert property (p_ew) else $error("select short");
	property p_aw; $rose(mem_we_n_out) |-> $past(mem_addr_out, 4) == mem_addr_out; endproperty
	a_aw: assert property (p_aw) else $error("addr late");
	property p_dw; $rose(mem_we_n_out)
		|-> $past(mem_data_oe_out, 2) && mem_data_oe_out && $stable(mem_data_out); endproperty
	a_dw: assert property (p_dw) else $error("data late");
	property p_rd; !mem_oe_n_out |-> mem_we_n_out && !mem_sel_n_out; endproperty
	a_rd: assert property (p_rd) else $error("gate outside read");
endmodule : dpsc_host_monitor

bind dpsc_host dpsc_host_monitor #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) mon_u (
	.clk_in          (clk_in),
	.reset_in        (reset_in),
	.pair_mode_in    (pair_mode_in),
	.mem_addr_out    (mem_addr_out),
	.mem_sel_n_out   (mem_sel_n_out),
	.mem_we_n_out    (mem_we_n_out),
	.mem_oe_n_out    (mem_oe_n_out),
	.mem_data_out    (mem_data_out),
	.mem_data_oe_out (mem_data_oe_out)
);

// File: dpsc_ram_model.sv
// behavioural model of one port of the shared ram
// assumes host data reaches it only with host enable high
module dpsc_ram_model
	import dpsc_pkg::*;
(
	input  wire logic        sel_n_in,
	input  wire logic        we_n_in,
	input  wire logic        oe_n_in,
	input  wire logic [10:0] addr_in,
	input  wire logic [7:0]  host_data_in,
	input  wire logic        host_oe_in,
	output logic      [7:0]  bus_out
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] mem_q [2048];
	logic [7:0] last_q = 8'h00;
	logic       drv;
	// one host port only, so no address conflict raises busy
	assign drv = !sel_n_in && !oe_n_in && we_n_in;
	always @(posedge (sel_n_in | we_n_in))
		if (host_oe_in === 1'b1)
			mem_q[addr_in] = host_data_in;
	always @(drv or addr_in)
		if (drv)
			last_q = mem_q[addr_in];
	// released bus shows inverse, never a stale match
	assign #2 bus_out = host_oe_in ? host_data_in : drv ? mem_q[addr_in] : ~last_q;
endmodule : dpsc_ram_model

// File: dpsc_host_tb.sv
// random write and read-back bench for dpsc_host
// assumes the ram model stands on the memory pins
module dpsc_host_tb
	import dpsc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_in, reset_in, req_in, req_write_in, pair_mode_in, req_ready_out, rdata_valid_out;
	logic mem_sel_n_out, mem_we_n_out, mem_oe_n_out, mem_data_oe_out;
	logic [10:0] req_addr_in, mem_addr_out, a;
	logic [7:0]  req_wdata_in, rdata_out, mem_data_in, mem_data_out;
	logic [7:0]  ref_q [2048];
	int          seed = 15287;
	int          bad_count, cmp_count, cyc;
	dpsc_host dut_u (
		.clk_in          (clk_in),
		.reset_in        (reset_in),
		.req_in          (req_in),
		.req_write_in    (req_write_in),
		.req_addr_in     (req_addr_in),
		.req_wdata_in    (req_wdata_in),
		.pair_mode_in    (pair_mode_in),
		.req_ready_out   (req_ready_out),
		.rdata_valid_out (rdata_valid_out),
		.rdata_out       (rdata_out),
		.mem_addr_out    (mem_addr_out),
		.mem_sel_n_out   (mem_sel_n_out),
		.mem_we_n_out    (mem_we_n_out),
		.mem_oe_n_out    (mem_oe_n_out),
		.mem_data_in     (mem_data_in),
		.mem_data_out    (mem_data_out),
		.mem_data_oe_out (mem_data_oe_out)
	);
	dpsc_ram_model ram_u (.sel_n_in(mem_sel_n_out), .we_n_in(mem_we_n_out),
		.oe_n_in(mem_oe_n_out), .addr_in(mem_addr_out), .host_data_in(mem_data_out),
		.host_oe_in(mem_data_oe_out), .bus_out(mem_data_in));
	initial
	begin
		clk_in = 0;
		forever #5 clk_in = ~clk_in;
	end
	always @(posedge clk_in)
	begin
		cyc++;
		if (cyc > 3000)
		begin
			bad_count++;
			wrap_up();
		end
	end
	function automatic int lat(input logic w, input logic p);
		int n;
		// strobe low for the longest of width, select and output-off plus setup
		n = (WZ_DW_CYC > EW_CYC) ? WZ_DW_CYC : EW_CYC;
		n = (n > WP_CYC) ? n : WP_CYC;
		return w ? (1 + n + WR_CYC + (p ? BAA_CYC : 0)) : (1 + RC_CYC + HZ_CYC);
	endfunction : lat
	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		cmp_count++;
		if (s !== e)
		begin
			bad_count++;
			$display("BAD %0t seen %h exp %h", $time, s, e);
		end
	endtask : chk
	task automatic wrap_up();
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : wrap_up
	task automatic op(input logic w, input logic [10:0] ad);
		int t;
		int nv;
		t = 0;
		nv = 0;
		@(negedge clk_in);
		req_in = 1;
		req_write_in = w;
		req_addr_in = ad;
		req_wdata_in = 8'($random(seed));
		pair_mode_in = 1'($random(seed));
		if (w)
			ref_q[ad] = req_wdata_in;
		@(posedge clk_in);
		#1;
		while (req_ready_out !== 1'b1 && t < 30)
		begin
			@(negedge clk_in);
			// early requests while busy must be dropped
			req_in = t < 3;
			req_addr_in = 11'($random(seed));
			@(posedge clk_in);
			#1;
			t++;
			if (rdata_valid_out === 1'b1)
			begin
				nv++;
				chk(16'(t), 16'(1 + RC_CYC));
				chk({8'h00, rdata_out}, {8'h00, ref_q[ad]});
			end
		end
		chk(16'(t), 16'(lat(w, pair_mode_in)));
		chk(16'(nv), {15'h0, !w});
	endtask : op
	initial
	begin
		{reset_in, req_in, req_write_in, pair_mode_in} = 4'h8;
		{req_addr_in, req_wdata_in} = 19'h0;
		repeat (5) @(posedge clk_in);
		@(negedge clk_in);
		reset_in = 0;
		for (int k = 0; k < 40; k++)
		begin
			a = (k == 0) ? 11'h000 : (k == 1) ? 11'h7ff : 11'($random(seed));
			op(1, a);
			op(0, a);
		end
		op(0, 11'h000);
		wrap_up();
	end
endmodule : dpsc_host_tb
